/* bench/eqm_mgmt_host.sv */
// management controller model issuing portal requests
`timescale 1ns/100ps
module eqm_mgmt_host
   import eqm_pkg::*;
(
   // clock
   input wire logic clk,
   // register access
   output eqm_req_t req,
   input wire eqm_rsp_t rsp_ff
);
   initial req = '0;
   // released lines show inverted values so stale data cannot pass
   task automatic access(input logic w, input logic [4:0] a, input logic [15:0] d,
      output logic [15:0] q);
      @(negedge clk);
      req <= '{wr: w, rd: !w, addr: a, wdata: d};
      @(negedge clk);
      q = rsp_ff.data;
      req <= '{wr: 1'h0, rd: 1'h0, addr: ~a, wdata: ~d};
   endtask : access

   task automatic mmd_open(input logic [4:0] dev, input logic [15:0] ofs, input logic [1:0] fn);
      logic [15:0] q;
      access(1'h1, PORTAL_CTRL_ADDR, {FUNC_ADDRESS, 9'h000, dev}, q);
      access(1'h1, PORTAL_DATA_ADDR, ofs, q);
      access(1'h1, PORTAL_CTRL_ADDR, {fn, 9'h000, dev}, q);
   endtask : mmd_open
endmodule : eqm_mgmt_host

/* bench/eqm_mmd_regs_asserts.sv */
// port checker for the eee and quality mmd register bank
`timescale 1ns/100ps
module eqm_mmd_regs_asserts
   import eqm_pkg::*;
#(
   parameter int REFRESH_CYC = 100
) (
   // clock and reset
   input wire logic       clk,
   input wire logic       sys_rst,
   // register access
   input wire eqm_req_t   req,
   input wire eqm_rsp_t   rsp_ff,
   // status and controls
   input wire logic       link_up,
   input wire logic       partner_eee_100,
   input wire logic       partner_eee_1000,
   input wire logic [6:0] quality_raw,
   input wire logic       eee_adv_100_ff,
   input wire logic       eee_adv_1000_ff,
   input wire logic [3:0] pulse_amp_ff
);
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   wire portal = req.addr == PORTAL_CTRL_ADDR || req.addr == PORTAL_DATA_ADDR;
   ////////////////////////////////////////
   gig_never_a:
      assert property (!eee_adv_1000_ff) else $error("gigabit eee advertised");
   rst_values_a:
      assert property ($past(sys_rst) |-> pulse_amp_ff == 4'h2 && !eee_adv_100_ff)
      else $error("control outputs wrong after reset");
   read_answer_a:
      assert property (req.rd |=> rsp_ff.valid) else $error("read not answered");
   no_answer_a:
      assert property (!req.rd |=> !rsp_ff.valid) else $error("answer without read");
   foreign_addr_a:
      assert property (req.rd && !portal |=> !rsp_ff.hit && rsp_ff.data == 16'h0000)
      else $error("foreign address answered");
   portal_hit_a:
      assert property (req.rd && portal |=> rsp_ff.hit) else $error("portal read missed");
   ctrl_resv_a:
      assert property (req.rd && req.addr == PORTAL_CTRL_ADDR |=> rsp_ff.data[13:5] == 9'h000)
      else $error("control reserved bits set");
   hold_ctrl_a:
      assert property (!req.wr |=> $stable(pulse_amp_ff) && $stable(eee_adv_100_ff))
      else $error("control output moved without write");
   idle_zero_a:
      assert property (!rsp_ff.valid |-> !rsp_ff.hit && rsp_ff.data == 16'h0000)
      else $error("idle answer not zero");
   cover property (req.rd && req.addr == PORTAL_DATA_ADDR);
   cover property (eee_adv_100_ff);
   cover property (pulse_amp_ff == 4'h7);
   cover property (link_up && req.rd && req.addr == PORTAL_DATA_ADDR);
   cover property (partner_eee_100 && partner_eee_1000);
endmodule : eqm_mmd_regs_asserts

bind eqm_mmd_regs eqm_mmd_regs_asserts #(.REFRESH_CYC(REFRESH_CYC)) u_asserts (
   .clk(clk), .sys_rst(sys_rst), .req(req), .rsp_ff(rsp_ff), .link_up(link_up),
   .partner_eee_100(partner_eee_100), .partner_eee_1000(partner_eee_1000),
   .quality_raw(quality_raw), .eee_adv_100_ff(eee_adv_100_ff),
   .eee_adv_1000_ff(eee_adv_1000_ff), .pulse_amp_ff(pulse_amp_ff));

/* bench/eqm_mmd_regs_tb.sv */
// self-checking bench for the eee and quality mmd register bank
`timescale 1ns/100ps
module eqm_mmd_regs_tb;
   import eqm_pkg::*;
   localparam int RC = 4;
   logic clk, sys_rst, link_up, p100, p1000, adv100, adv1000;
   logic [6:0]  qraw;
   logic [6:0]  qkeep;
   logic [3:0]  amp;
   logic [15:0] q;
   logic [31:0] lfsr = 32'h49579C04;
   eqm_req_t    req;
   eqm_rsp_t    rsp;
   int          error_cnt = 0;
   int          checked = 0;

   eqm_mmd_regs #(.REFRESH_CYC(RC)) uut (.clk(clk), .sys_rst(sys_rst), .req(req),
      .rsp_ff(rsp), .link_up(link_up), .partner_eee_100(p100), .partner_eee_1000(p1000),
      .quality_raw(qraw), .eee_adv_100_ff(adv100), .eee_adv_1000_ff(adv1000),
      .pulse_amp_ff(amp));
   eqm_mgmt_host host (.clk(clk), .req(req), .rsp_ff(rsp));
   ////////////////////////////////////////
   function automatic logic [31:0] step(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : step

   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      checked++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic rd(input logic [4:0] a);
      host.access(1'h0, a, 16'h0000, q);
   endtask : rd

   task automatic wr(input logic [4:0] a, input logic [15:0] d);
      host.access(1'h1, a, d, q);
   endtask : wr

   task automatic conclude;
      $display("checked %0d error_cnt %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : conclude

   initial begin
      clk = 1'h0;
      forever #5 clk = ~clk;
   end

   initial begin
      #100000;
      error_cnt++;
      conclude();
   end

   initial begin
      sys_rst = 1'h1;
      {link_up, p100, p1000, qraw} = '0;
      repeat (5) @(negedge clk);
      sys_rst = 1'h0;
      host.mmd_open(DEV_EEE, LOCAL_EEE_ADVERTISE_OFS, FUNC_DATA_INC_RW);
      rd(PORTAL_DATA_ADDR);
      check("adv reset", q, 16'h0000);
      rd(PORTAL_DATA_ADDR);
      check("partner reset", q, 16'h0000);
      host.mmd_open(DEV_EEE, LOCAL_EEE_ADVERTISE_OFS, FUNC_DATA_INC_WR);
      wr(PORTAL_DATA_ADDR, 16'hFFFF);
      for (int i = 0; i < 4; i++) begin
         {p1000, p100} = i[1:0];
         rd(PORTAL_DATA_ADDR);
         check("partner", q, {13'h0000, p1000, p100, 1'h0});
      end
      host.mmd_open(DEV_EEE, LOCAL_EEE_ADVERTISE_OFS, FUNC_DATA);
      rd(PORTAL_DATA_ADDR);
      check("adv", q, LOCAL_EEE_ADVERTISE_WMASK);
      check("adv out", adv100, 1'h1);
      check("gig out", adv1000, 1'h0);
      host.mmd_open(DEV_FRONT_END, FRONT_END_PULSE_CONTROL_OFS, FUNC_DATA);
      rd(PORTAL_DATA_ADDR);
      check("pulse reset", q, 16'h0020);
      lfsr = step(lfsr);
      wr(PORTAL_DATA_ADDR, {lfsr[15:8], 4'h7, lfsr[3:0]});
      rd(PORTAL_DATA_ADDR);
      check("pulse", q, {lfsr[15:8], 4'h7, lfsr[3:0]});
      check("amp", amp, 4'h7);
      rd(PORTAL_CTRL_ADDR);
      check("ctrl", q, {FUNC_DATA, 9'h000, DEV_FRONT_END});
      check("ctrl answer", {rsp.valid, rsp.hit}, 2'h3);
      wr(5'h02, 16'h0000);
      rd(5'h01);
      check("foreign", {q[15:4], amp}, 16'h0007);
      check("foreign answer", {rsp.valid, rsp.hit}, 2'h2);
      host.mmd_open(DEV_QUALITY, RECEIVE_QUALITY_INDEX_OFS, FUNC_DATA);
      link_up = 1'h1;
      for (int i = 0; i < 5; i++) begin
         lfsr = step(lfsr);
         qkeep = qraw;
         // last pass drops the link with a differing raw value: the old index must stay
         qraw = (i == 0) ? 7'h7F : (i == 4) ? ~qkeep : lfsr[6:0];
         link_up = (i < 4);
         repeat (RC + 3) @(negedge clk);
         if (i < 4) begin
            rd(PORTAL_DATA_ADDR);
            check("quality", q, {1'h0, qraw, 8'h00});
         end
         else begin
            rd(PORTAL_DATA_ADDR);
            check("quality held", q, {1'h0, qkeep, 8'h00});
         end
      end
      sys_rst = 1'h1;
      repeat (2) @(negedge clk);
      sys_rst = 1'h0;
      check("amp rst", amp, 4'h2);
      check("adv rst", adv100, 1'h0);
      host.mmd_open(DEV_EEE, LOCAL_EEE_ADVERTISE_OFS, FUNC_DATA);
      rd(PORTAL_DATA_ADDR);
      check("adv reg rst", q, LOCAL_EEE_ADVERTISE_RST);
      conclude();
   end
endmodule : eqm_mmd_regs_tb

/* verilog/eqm_mmd_regs.sv */
// local_eee_advertise, partner ability, pulse amplitude and quality index behind the mmd portal
// How it works
// [RULE1] 100M EEE advertised only when advertisement bit 1 is set; resets to zero.
// [RULE2] gigabit Local_eee_advertise bit reads zero; never advertised.
// [RULE3] partner bit 1 reads partner's 100M EEE ability; resets zero.
// [RULE4] partner bit 2 reads partner's gigabit EEE ability; resets zero.
// [RULE5] pulse amplitude field bits 7:4, resets 0x2, 0x7 gives large pulse.
// [RULE6] seven-bit quality index in bits 14:8; lower is better.
// [RULE7] portal function: address, data, data inc on all, data inc on writes.
// [RULE8] five-bit device select in portal control picks the mmd device.
// [RULE9] quality index refreshed periodically while link is up.
`timescale 1ns/100ps
module eqm_mmd_regs #(
   parameter int REFRESH_CYC = eqm_pkg::QI_REFRESH_CYC
) (
   // clock and reset
   input  wire logic             clk,
   input  wire logic             sys_rst,
   // clause-22 register access from the management frame decoder
   input  wire eqm_pkg::eqm_req_t req,
   output eqm_pkg::eqm_rsp_t     rsp_ff,
   // link partner and receiver status
   input  wire logic             link_up,
   input  wire logic             partner_eee_100,
   input  wire logic             partner_eee_1000,
   input  wire logic [6:0]       quality_raw,
   // controls to eee and diagnostic logic
   output logic                  eee_adv_100_ff,
   output logic                  eee_adv_1000_ff,
   output logic [3:0]            pulse_amp_ff
);
   import eqm_pkg::*;

   logic [1:0]  func_ff;
   logic [1:0]  nxt_func;
   logic [4:0]  devsel_ff;
   logic [4:0]  nxt_devsel;
   logic [15:0] mmd_addr_ff;
   logic [15:0] nxt_mmd_addr;
   logic [15:0] adv_ff;
   logic [15:0] nxt_adv;
   logic [15:0] pulse_ctl_ff;
   logic [15:0] nxt_pulse_ctl;
   logic [1:0]  partner_ff;
   logic [1:0]  nxt_partner;
   eqm_rsp_t    nxt_rsp;
   logic        nxt_adv_100;
   logic [3:0]  nxt_amp;
   logic [6:0]  quality;
   logic        data_acc;
   logic        inc;
   logic [15:0] mmd_rdata;
   logic [15:0] eh_rdata;

   ////////////////////////////////////////////////////////////////////////////////
   // quality index sampling
   eqm_quality_sampler #(
      .REFRESH_CYC (REFRESH_CYC)
   ) u_sampler (
      .clk         (clk),
      .sys_rst     (sys_rst),
      .link_up     (link_up),
      .quality_raw (quality_raw),
      .quality_ff  (quality)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // indirect register read mux; unmapped registers read zero
   always_comb begin
      mmd_rdata = 16'h0000;
      if (devsel_ff == DEV_EEE && mmd_addr_ff == LOCAL_EEE_ADVERTISE_OFS) begin
         mmd_rdata = adv_ff & LOCAL_EEE_ADVERTISE_WMASK; // [RULE2]
      end else if (devsel_ff == DEV_EEE && mmd_addr_ff == PARTNER_EEE_ABILITY_OFS) begin
         mmd_rdata[EEE_100_BIT]  = partner_ff[0]; // [RULE3]
         mmd_rdata[EEE_1000_BIT] = partner_ff[1]; // [RULE4]
      end else if (devsel_ff == DEV_FRONT_END
                   && mmd_addr_ff == FRONT_END_PULSE_CONTROL_OFS) begin
         mmd_rdata = pulse_ctl_ff;
      end else if (devsel_ff == DEV_QUALITY && mmd_addr_ff == RECEIVE_QUALITY_INDEX_OFS) begin
         mmd_rdata[QI_MSB:QI_LSB] = quality; // [RULE6]
      end
      eh_rdata = (func_ff == FUNC_ADDRESS) ? mmd_addr_ff : mmd_rdata; // [RULE7]
   end

   ////////////////////////////////////////////////////////////////////////////////
   // portal state and register writes
   always_comb begin
      nxt_func      = func_ff;
      nxt_devsel    = devsel_ff;
      nxt_mmd_addr  = mmd_addr_ff;
      nxt_adv       = adv_ff;
      nxt_pulse_ctl = pulse_ctl_ff;
      nxt_partner   = {partner_eee_1000, partner_eee_100}; // [RULE3] [RULE4]
      data_acc      = (req.addr == PORTAL_DATA_ADDR) && (func_ff != FUNC_ADDRESS);
      inc           = 1'b0;
      if (req.wr && req.addr == PORTAL_CTRL_ADDR) begin
         nxt_func   = req.wdata[FUNC_MSB:FUNC_LSB]; // [RULE7]
         nxt_devsel = req.wdata[DEVSEL_MSB:0]; // [RULE8]
      end else if (req.wr && req.addr == PORTAL_DATA_ADDR) begin
         if (func_ff == FUNC_ADDRESS) begin
            nxt_mmd_addr = req.wdata; // [RULE7]
         end else begin
            // writes land in the device that the portal selects
            if (devsel_ff == DEV_EEE && mmd_addr_ff == LOCAL_EEE_ADVERTISE_OFS) begin
               nxt_adv = req.wdata & LOCAL_EEE_ADVERTISE_WMASK; // [RULE1] [RULE2] [RULE8]
            end
            if (devsel_ff == DEV_FRONT_END && mmd_addr_ff == FRONT_END_PULSE_CONTROL_OFS) begin
               nxt_pulse_ctl = req.wdata; // [RULE5] [RULE8]
            end
            inc = (func_ff == FUNC_DATA_INC_RW) || (func_ff == FUNC_DATA_INC_WR); // [RULE7]
         end
      end else if (req.rd && data_acc) begin
         inc = (func_ff == FUNC_DATA_INC_RW); // [RULE7]
      end
      if (inc) begin
         nxt_mmd_addr = mmd_addr_ff + 16'h0001;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // read answer one cycle after the strobe; other addresses answer with hit low
   always_comb begin
      nxt_rsp       = '0;
      nxt_rsp.valid = req.rd;
      if (req.rd && req.addr == PORTAL_CTRL_ADDR) begin
         nxt_rsp.hit  = 1'b1;
         nxt_rsp.data = {func_ff, 9'h000, devsel_ff};
      end else if (req.rd && req.addr == PORTAL_DATA_ADDR) begin
         nxt_rsp.hit  = 1'b1;
         nxt_rsp.data = eh_rdata;
      end
      nxt_adv_100 = nxt_adv[EEE_100_BIT]; // [RULE1]
      nxt_amp     = nxt_pulse_ctl[AMP_MSB:AMP_LSB]; // [RULE5]
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         func_ff         <= FUNC_RST;
         devsel_ff       <= DEVSEL_RST;
         mmd_addr_ff     <= MMD_ADDR_RST;
         adv_ff          <= LOCAL_EEE_ADVERTISE_RST; // [RULE1]
         pulse_ctl_ff    <= FRONT_END_PULSE_CONTROL_RST; // [RULE5]
         partner_ff      <= PARTNER_RST;
         rsp_ff          <= '0;
         eee_adv_100_ff  <= 1'b0;
         eee_adv_1000_ff <= 1'b0;
         pulse_amp_ff    <= FRONT_END_PULSE_CONTROL_RST[AMP_MSB:AMP_LSB];
      end else begin
         func_ff         <= nxt_func;
         devsel_ff       <= nxt_devsel;
         mmd_addr_ff     <= nxt_mmd_addr;
         adv_ff          <= nxt_adv;
         pulse_ctl_ff    <= nxt_pulse_ctl;
         partner_ff      <= nxt_partner;
         rsp_ff          <= nxt_rsp;
         eee_adv_100_ff  <= nxt_adv_100;
         eee_adv_1000_ff <= 1'b0; // [RULE2]
         pulse_amp_ff    <= nxt_amp;
      end
   end

endmodule : eqm_mmd_regs

/* verilog/eqm_pkg.sv */
// shared constants and carriers for the eee and signal quality management registers
package eqm_pkg;

   ////////////////////////////////////////////////////////////////////////////////
   // clause-22 portal addresses
   localparam logic [4:0]  PORTAL_CTRL_ADDR     = 5'h0D;
   localparam logic [4:0]  PORTAL_DATA_ADDR     = 5'h0E;

   // portal control field positions
   localparam int          FUNC_MSB             = 15;
   localparam int          FUNC_LSB             = 14;
   localparam int          DEVSEL_MSB           = 4;

   // function codes of the portal
   localparam logic [1:0]  FUNC_ADDRESS         = 2'h0;
   localparam logic [1:0]  FUNC_DATA            = 2'h1;
   localparam logic [1:0]  FUNC_DATA_INC_RW     = 2'h2;
   localparam logic [1:0]  FUNC_DATA_INC_WR     = 2'h3;

   ////////////////////////////////////////////////////////////////////////////////
   // mmd devices and register offsets
   localparam logic [4:0]  DEV_EEE              = 5'h07;
   localparam logic [4:0]  DEV_FRONT_END        = 5'h1B;
   localparam logic [4:0]  DEV_QUALITY          = 5'h1C;
   localparam logic [15:0] LOCAL_EEE_ADVERTISE_OFS     = 16'h003C;
   localparam logic [15:0] PARTNER_EEE_ABILITY_OFS     = 16'h003D;
   localparam logic [15:0] FRONT_END_PULSE_CONTROL_OFS = 16'h0000;
   localparam logic [15:0] RECEIVE_QUALITY_INDEX_OFS   = 16'h00AC;

   // field positions
   localparam int          EEE_100_BIT          = 1;
   localparam int          EEE_1000_BIT         = 2;
   localparam int          AMP_MSB              = 7;
   localparam int          AMP_LSB              = 4;
   localparam int          QI_MSB               = 14;
   localparam int          QI_LSB               = 8;

   // writable bits of the advertisement register (7:3, 1, 0)
   localparam logic [15:0] LOCAL_EEE_ADVERTISE_WMASK   = 16'h00FB;

   // reset values
   localparam logic [15:0] LOCAL_EEE_ADVERTISE_RST     = 16'h0000;
   localparam logic [15:0] FRONT_END_PULSE_CONTROL_RST = 16'h0020;
   localparam logic [15:0] MMD_ADDR_RST                = 16'h0000;
   localparam logic [1:0]  FUNC_RST                    = 2'h0;
   localparam logic [4:0]  DEVSEL_RST                  = 5'h00;
   localparam logic [1:0]  PARTNER_RST                 = 2'h0;
   localparam logic [6:0]  QI_RST                      = 7'h00;

   ////////////////////////////////////////////////////////////////////////////////
   // timing
   localparam int          CLK_PERIOD_NS        = 10;
   localparam int          QI_REFRESH_NS        = 1000;
   localparam int          QI_REFRESH_CYC       = QI_REFRESH_NS / CLK_PERIOD_NS;

   ////////////////////////////////////////////////////////////////////////////////
   // carriers
   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [4:0]  addr;
      logic [15:0] wdata;
   } eqm_req_t;

   typedef struct packed {
      logic        valid;
      logic        hit;
      logic [15:0] data;
   } eqm_rsp_t;

endpackage : eqm_pkg

/* verilog/eqm_quality_sampler.sv */
// periodic sampler of the receive signal quality index
`timescale 1ns/100ps
module eqm_quality_sampler #(
   parameter int REFRESH_CYC = eqm_pkg::QI_REFRESH_CYC
) (
   // clock and reset
   input  wire logic       clk,
   input  wire logic       sys_rst,
   // measurement
   input  wire logic       link_up,
   input  wire logic [6:0] quality_raw,
   // held index
   output logic [6:0]      quality_ff
);
   import eqm_pkg::*;

   generate
      if (REFRESH_CYC < 1) begin : g_bad_refresh
         $error("eqm_quality_sampler: REFRESH_CYC must be at least 1");
      end
   endgenerate

   localparam int CW = $clog2(REFRESH_CYC + 1);
   localparam logic [CW-1:0] LAST = CW'(REFRESH_CYC - 1);

   logic [CW-1:0] div_ff;
   logic [CW-1:0] nxt_div;
   logic          tick;
   logic [6:0]    nxt_quality;

   ////////////////////////////////////////////////////////////////////////////////
   // refresh enable; held while no link so the last good index stays readable
   always_comb begin
      tick        = link_up && (div_ff == LAST);
      nxt_div     = div_ff;
      nxt_quality = quality_ff;
      if (!link_up) begin
         nxt_div = '0;
      end else if (tick) begin
         nxt_div     = '0;
         nxt_quality = quality_raw; // [RULE9]
      end else begin
         nxt_div = div_ff + CW'(1);
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         div_ff     <= '0;
         quality_ff <= QI_RST;
      end else begin
         div_ff     <= nxt_div;
         quality_ff <= nxt_quality;
      end
   end

endmodule : eqm_quality_sampler
